// ---- src/adcpc_cmp.sv ----
`timescale 1ns/1ps
package adcpc_pkg;
    localparam int RES_W  = 10;
    localparam int ACC_W  = 18;
    localparam int CNT_W  = 8;
    localparam int THR_W  = 16;
    localparam int ERR_W  = 20;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [ERR_W-1:0] ACC_MAX = 20'h3FFFF;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_REP  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_UTH  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LTH  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STPT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_RES  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_ACC  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_FLTR = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h20;
    localparam logic [ADDR_W-1:0] REG_ERR  = 8'h24;

    // control field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DBL_BIT   = 3;
    localparam int CTRL_PSRC_BIT  = 4;
    localparam int CTRL_SHIFT_LSB = 8;
    localparam int CTRL_TMD_LSB   = 12;
    localparam int CTRL_ESEL_LSB  = 16;
    localparam int CTRL_CLR_BIT   = 24;
    // status and result field positions
    localparam int STAT_OVF_BIT   = 8;
    localparam int STAT_DONE_BIT  = 9;
    localparam int STAT_THR_BIT   = 10;
    localparam int RES_PREV_LSB   = 16;

    typedef enum logic [2:0] {
        ADCPC_BASIC = 3'h0,
        ADCPC_ACCUM = 3'h1,
        ADCPC_AVG   = 3'h2,
        ADCPC_BURST = 3'h3,
        ADCPC_LPF   = 3'h4
    } adcpc_mode_type;

    typedef enum logic [2:0] {
        ADCPC_T_NEVER   = 3'h0,
        ADCPC_T_LT_LO   = 3'h1,
        ADCPC_T_GE_LO   = 3'h2,
        ADCPC_T_INSIDE  = 3'h3,
        ADCPC_T_OUTSIDE = 3'h4,
        ADCPC_T_LE_HI   = 3'h5,
        ADCPC_T_GT_HI   = 3'h6,
        ADCPC_T_ALWAYS  = 3'h7
    } adcpc_tmd_type;

    typedef enum logic [2:0] {
        ADCPC_C_DERIV    = 3'h0,
        ADCPC_C_CVD      = 3'h1,
        ADCPC_C_STPT     = 3'h2,
        ADCPC_C_RES_FLT  = 3'h3,
        ADCPC_C_FLT_DERV = 3'h4,
        ADCPC_C_FLT_STPT = 3'h5,
        ADCPC_C_RSVD6    = 3'h6,
        ADCPC_C_RSVD7    = 3'h7
    } adcpc_error_select_a_type;

    function automatic logic adcpc_mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_REP || a == REG_UTH || a == REG_LTH || a == REG_STPT ||
               a == REG_RES || a == REG_ACC || a == REG_FLTR || a == REG_STAT || a == REG_ERR;
    endfunction
endpackage

module adcpc_cmp
    import adcpc_pkg::*;
(
    input  wire logic signed [ERR_W-1:0] err,
    input  wire logic signed [THR_W-1:0] uth,
    input  wire logic signed [THR_W-1:0] lth,
    input  wire adcpc_tmd_type           tmd,
    output logic                         hit
);
    logic signed [ERR_W-1:0] hi;
    logic signed [ERR_W-1:0] lo;

    always_comb begin
        hi = ERR_W'(uth);
        lo = ERR_W'(lth);
        // all comparisons signed
        unique case (tmd)
            ADCPC_T_NEVER:   hit = 1'b0;
            ADCPC_T_LT_LO:   hit = err < lo;
            ADCPC_T_GE_LO:   hit = err >= lo;
            ADCPC_T_INSIDE:  hit = err >= lo && err <= hi;
            ADCPC_T_OUTSIDE: hit = err < lo || err > hi;
            ADCPC_T_LE_HI:   hit = err <= hi;
            ADCPC_T_GT_HI:   hit = err > hi;
            ADCPC_T_ALWAYS:  hit = 1'b1;
        endcase
    end
endmodule

// ---- src/adcpc_top.sv ----
`timescale 1ns/1ps
// Function
// - basic mode: no accumulation, test every sample
// - done flag every conversion; threshold flag conditional
// - accumulate mode adds result, advances counter
// - counter increments, holds at maximum
// - overflow flag when sum exceeds 18 bits
// - clear request zeroes accumulator, flag, counter
// - clearing completes within five clock cycles
// - filter output is accumulator shifted right
// - accumulate mode tests every sample, using the selected error
// - average mode tests once counter reaches target
// - average restart clears when target met
// - burst: clear at start, retrigger until target
// - lowpass: sample plus acc minus shifted acc
// - double sampling uses second minus first
// - overflow absent in basic; flags threshold
// - old result copied to previous when select zero
// - threshold comparisons are signed
module adcpc_top
    import adcpc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              conv_done,
    input  wire logic [RES_W-1:0]  conv_data,
    input  wire logic              start_evt,
    output logic                   retrigger,
    output logic                   conversion_done_flag,
    output logic                   channel_threshold_flag,
    output logic                   accumulator_overflow_flag
);
    typedef struct packed {
        adcpc_mode_type    compute_mode_select;
        logic              double_sample_enable;
        logic              previous_source_select;
        logic [2:0]        shift_count_field;
        adcpc_tmd_type     tmd;
        adcpc_error_select_a_type    error_select_a;
        logic              accumulator_clear_request;
        logic [CNT_W-1:0]  repeat_target;
        logic [THR_W-1:0]  uth;
        logic [THR_W-1:0]  lth;
        logic [THR_W-1:0]  stpt;
        logic [RES_W-1:0]  conversion_result;
        logic [RES_W-1:0]  previous_result;
        logic [RES_W-1:0]  first;
        logic              phase;
        logic [ACC_W-1:0]  sum_accumulator;
        logic              accumulator_overflow_flag;
        logic [CNT_W-1:0]  sample_counter;
        logic [ACC_W-1:0]  filter_output;
        logic [ERR_W-1:0]  err;
        logic              conversion_done_flag;
        logic              channel_threshold_flag;
        logic              retrigger;
        logic [DATA_W-1:0] prdata;
    } adcpc_state_type;

    adcpc_state_type st_ff;
    adcpc_state_type nxt_st;

    logic                    cycle_done;
    logic                    wr;
    logic                    hit;
    logic                    test;
    logic                    ovf;
    logic signed [ERR_W-1:0] samp;
    logic signed [ERR_W-1:0] sum;
    logic signed [ERR_W-1:0] err_c;
    logic signed [ERR_W-1:0] res_s;
    logic signed [ERR_W-1:0] prv_s;
    logic signed [ERR_W-1:0] flt_s;
    logic signed [ERR_W-1:0] stp_s;
    logic [ACC_W-1:0]        acc_b;
    logic [CNT_W-1:0]        cnt_b;
    logic [CNT_W-1:0]        cnt_n;

    assign wr         = psel && penable && pwrite;
    // with double sampling a cycle needs the second conversion
    assign cycle_done = conv_done && (!st_ff.double_sample_enable || st_ff.phase);

    adcpc_cmp u_cmp (
        .err (err_c),
        .uth (st_ff.uth),
        .lth (st_ff.lth),
        .tmd (st_ff.tmd),
        .hit (hit)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.retrigger = 1'b0;
        samp  = '0;
        sum   = '0;
        ovf   = 1'b0;
        test  = 1'b0;
        err_c = '0;
        cnt_n = '0;
        acc_b = st_ff.sum_accumulator;
        cnt_b = st_ff.sample_counter;

        if (st_ff.accumulator_clear_request) begin
            // one-cycle clear, well inside the five-cycle allowance
            acc_b = '0;
            cnt_b = '0;
            nxt_st.accumulator_overflow_flag = 1'b0;
            nxt_st.accumulator_clear_request = 1'b0;
        end else if (start_evt) begin
            if (st_ff.compute_mode_select == ADCPC_BURST ||
                (st_ff.compute_mode_select == ADCPC_AVG && cnt_b >= st_ff.repeat_target)) begin
                acc_b = '0;
                cnt_b = '0;
            end
        end

        // second minus first when double sampling
        samp = ERR_W'(conv_data) - (st_ff.double_sample_enable ? ERR_W'(st_ff.first) : ERR_W'(0));
        if (st_ff.compute_mode_select == ADCPC_LPF) begin
            sum = ERR_W'(acc_b) + samp - ERR_W'(acc_b >> st_ff.shift_count_field);
        end else begin
            sum = ERR_W'(acc_b) + samp;
        end
        cnt_n = (cnt_b == CNT_MAX) ? cnt_b : cnt_b + CNT_W'(1);

        if (conv_done) begin
            nxt_st.conversion_done_flag = 1'b1;
            nxt_st.phase = st_ff.double_sample_enable ? !st_ff.phase : 1'b0;
            if (!st_ff.phase) begin
                nxt_st.first = conv_data;
            end
            if (!st_ff.previous_source_select) begin
                nxt_st.previous_result = st_ff.conversion_result;
            end else begin
                nxt_st.previous_result = st_ff.filter_output[RES_W-1:0];
            end
            nxt_st.conversion_result = conv_data;
        end

        if (cycle_done && !st_ff.accumulator_clear_request) begin
            if (st_ff.compute_mode_select == ADCPC_BASIC) begin
                test = 1'b1;
            end else begin
                acc_b = sum[ACC_W-1:0];
                cnt_b = cnt_n;
                ovf   = sum > $signed(ACC_MAX);
                unique case (st_ff.compute_mode_select)
                    ADCPC_ACCUM: test = 1'b1;
                    ADCPC_BURST: begin
                        test = cnt_n >= st_ff.repeat_target;
                        nxt_st.retrigger = cnt_n < st_ff.repeat_target;
                    end
                    default:     test = cnt_n >= st_ff.repeat_target;
                endcase
            end
        end

        nxt_st.sum_accumulator = acc_b;
        nxt_st.sample_counter  = cnt_b;
        nxt_st.filter_output   = acc_b >> st_ff.shift_count_field;
        if (ovf) begin
            nxt_st.accumulator_overflow_flag = 1'b1;
        end

        // error from freshly stored values
        res_s = ERR_W'(conv_data);
        prv_s = st_ff.double_sample_enable ? ERR_W'(st_ff.first) : ERR_W'(st_ff.conversion_result);
        flt_s = ERR_W'(nxt_st.filter_output);
        stp_s = ERR_W'($signed(st_ff.stpt));
        unique case (st_ff.error_select_a)
            ADCPC_C_STPT:     err_c = res_s - stp_s;
            ADCPC_C_RES_FLT:  err_c = res_s - flt_s;
            ADCPC_C_FLT_DERV: err_c = flt_s - ERR_W'(st_ff.filter_output);
            ADCPC_C_FLT_STPT: err_c = flt_s - stp_s;
            default:          err_c = res_s - prv_s;
        endcase
        if (test) begin
            nxt_st.err = err_c;
        end

        // register writes; hardware sets win over software clears
        if (wr) begin
            unique case (paddr)
                REG_CTRL: begin
                    nxt_st.compute_mode_select    = adcpc_mode_type'(pwdata[CTRL_MODE_LSB +: 3]);
                    nxt_st.double_sample_enable   = pwdata[CTRL_DBL_BIT];
                    nxt_st.previous_source_select = pwdata[CTRL_PSRC_BIT];
                    nxt_st.shift_count_field      = pwdata[CTRL_SHIFT_LSB +: 3];
                    nxt_st.tmd                    = adcpc_tmd_type'(pwdata[CTRL_TMD_LSB +: 3]);
                    nxt_st.error_select_a         = adcpc_error_select_a_type'(pwdata[CTRL_ESEL_LSB +: 3]);
                    if (pwdata[CTRL_CLR_BIT]) begin
                        nxt_st.accumulator_clear_request = 1'b1;
                    end
                end
                REG_REP:  nxt_st.repeat_target = pwdata[CNT_W-1:0];
                REG_UTH:  nxt_st.uth = pwdata[THR_W-1:0];
                REG_LTH:  nxt_st.lth = pwdata[THR_W-1:0];
                REG_STPT: nxt_st.stpt = pwdata[THR_W-1:0];
                REG_STAT: begin
                    if (pwdata[STAT_DONE_BIT] && !conv_done) begin
                        nxt_st.conversion_done_flag = 1'b0;
                    end
                    if (pwdata[STAT_THR_BIT]) begin
                        nxt_st.channel_threshold_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // overflow reported alongside threshold
        if (test && (hit || st_ff.accumulator_overflow_flag || ovf)) begin
            nxt_st.channel_threshold_flag = 1'b1;
        end

        // read data captured in setup so it stands through access
        if (psel && !penable) begin
            nxt_st.prdata = '0;
            unique case (paddr)
                REG_CTRL: begin
                    nxt_st.prdata[CTRL_MODE_LSB +: 3] = st_ff.compute_mode_select;
                    nxt_st.prdata[CTRL_DBL_BIT]        = st_ff.double_sample_enable;
                    nxt_st.prdata[CTRL_PSRC_BIT]       = st_ff.previous_source_select;
                    nxt_st.prdata[CTRL_SHIFT_LSB +: 3] = st_ff.shift_count_field;
                    nxt_st.prdata[CTRL_TMD_LSB +: 3]   = st_ff.tmd;
                    nxt_st.prdata[CTRL_ESEL_LSB +: 3]  = st_ff.error_select_a;
                    nxt_st.prdata[CTRL_CLR_BIT]        = st_ff.accumulator_clear_request;
                end
                REG_REP:  nxt_st.prdata[CNT_W-1:0] = st_ff.repeat_target;
                REG_UTH:  nxt_st.prdata[THR_W-1:0] = st_ff.uth;
                REG_LTH:  nxt_st.prdata[THR_W-1:0] = st_ff.lth;
                REG_STPT: nxt_st.prdata[THR_W-1:0] = st_ff.stpt;
                REG_RES: begin
                    nxt_st.prdata[RES_W-1:0]                = st_ff.conversion_result;
                    nxt_st.prdata[RES_PREV_LSB +: RES_W]   = st_ff.previous_result;
                end
                REG_ACC:  nxt_st.prdata[ACC_W-1:0] = st_ff.sum_accumulator;
                REG_FLTR: nxt_st.prdata[ACC_W-1:0] = st_ff.filter_output;
                REG_STAT: begin
                    nxt_st.prdata[CNT_W-1:0]     = st_ff.sample_counter;
                    nxt_st.prdata[STAT_OVF_BIT]  = st_ff.accumulator_overflow_flag;
                    nxt_st.prdata[STAT_DONE_BIT] = st_ff.conversion_done_flag;
                    nxt_st.prdata[STAT_THR_BIT]  = st_ff.channel_threshold_flag;
                end
                REG_ERR:  nxt_st.prdata[ERR_W-1:0] = st_ff.err;
                default:  nxt_st.prdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata                    = st_ff.prdata;
    assign pready                    = 1'b1;
    assign pslverr                   = psel && penable && !adcpc_mapped(paddr);
    assign retrigger                 = st_ff.retrigger;
    assign conversion_done_flag      = st_ff.conversion_done_flag;
    assign channel_threshold_flag    = st_ff.channel_threshold_flag;
    assign accumulator_overflow_flag = st_ff.accumulator_overflow_flag;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    localparam int CLR_LO = 1;
    localparam int CLR_HI = 5;

    AST_BASIC_HOLD: assert property (
        cycle_done && st_ff.compute_mode_select == ADCPC_BASIC && !st_ff.accumulator_clear_request && !start_evt
        |=> $stable(st_ff.sum_accumulator))
        else $error("basic mode changed accumulator");
    AST_DONE_SET: assert property (conv_done |=> st_ff.conversion_done_flag)
        else $error("done flag not set after conversion");
    AST_ACC_ADD: assert property (
        cycle_done && st_ff.compute_mode_select == ADCPC_ACCUM && !st_ff.double_sample_enable &&
        !st_ff.accumulator_clear_request && !start_evt
        |=> st_ff.sum_accumulator == ACC_W'($past(st_ff.sum_accumulator) + ACC_W'($past(conv_data))))
        else $error("accumulate mode sum wrong");
    AST_CNT_SAT: assert property (
        cycle_done && st_ff.sample_counter == CNT_MAX && st_ff.compute_mode_select == ADCPC_ACCUM &&
        !st_ff.accumulator_clear_request
        |=> st_ff.sample_counter == CNT_MAX)
        else $error("counter did not saturate");
    AST_AOV_SET: assert property (ovf |=> st_ff.accumulator_overflow_flag)
        else $error("overflow not flagged");
    AST_ACCUMULATOR_CLEAR_REQUEST_ZERO: assert property (
        st_ff.accumulator_clear_request |=> st_ff.sum_accumulator == '0 && st_ff.sample_counter == '0 &&
        !st_ff.accumulator_overflow_flag)
        else $error("clear did not zero state");
    AST_ACCUMULATOR_CLEAR_REQUEST_DONE: assert property (
        $rose(st_ff.accumulator_clear_request) |-> ##[CLR_LO:CLR_HI] !st_ff.accumulator_clear_request)
        else $error("clear bit stuck");
    AST_FLTR_SHIFT: assert property (
        ##1 st_ff.filter_output == (st_ff.sum_accumulator >> $past(st_ff.shift_count_field)))
        else $error("filter output mismatch");
    AST_AVG_RESTART: assert property (
        start_evt && !conv_done && !wr && st_ff.compute_mode_select == ADCPC_AVG &&
        st_ff.sample_counter >= st_ff.repeat_target
        |=> st_ff.sample_counter == '0 && st_ff.sum_accumulator == '0)
        else $error("average restart did not clear");
    AST_RETRIG_BURST: assert property (st_ff.retrigger |-> $past(st_ff.compute_mode_select) == ADCPC_BURST)
        else $error("retrigger outside burst mode");
    AST_PREV_COPY: assert property (
        conv_done && !st_ff.previous_source_select |=> st_ff.previous_result == $past(st_ff.conversion_result))
        else $error("previous result not copied");
    AST_RETRIG_CNT: assert property (
        st_ff.retrigger |-> st_ff.sample_counter < st_ff.repeat_target)
        else $error("retrigger with target reached");
    AST_LPF_STEP: assert property (
        cycle_done && st_ff.compute_mode_select == ADCPC_LPF && !st_ff.double_sample_enable &&
        !st_ff.accumulator_clear_request && !start_evt
        |=> st_ff.sum_accumulator == ACC_W'($past(st_ff.sum_accumulator) + ACC_W'($past(conv_data)) -
            ($past(st_ff.sum_accumulator) >> $past(st_ff.shift_count_field))))
        else $error("low-pass update wrong");
    AST_BASIC_NO_OVF: assert property (
        st_ff.compute_mode_select == ADCPC_BASIC && !st_ff.accumulator_overflow_flag
        |=> !st_ff.accumulator_overflow_flag)
        else $error("overflow flagged in basic mode");
    AST_DS_FIRST_HOLD: assert property (
        conv_done && st_ff.double_sample_enable && !st_ff.phase && !st_ff.accumulator_clear_request && !start_evt
        |=> $stable(st_ff.sum_accumulator))
        else $error("first of a double sample changed accumulator");
    AST_AVG_TEST_CNT: assert property (
        test && !wr && st_ff.compute_mode_select == ADCPC_AVG
        |=> st_ff.sample_counter >= st_ff.repeat_target)
        else $error("average test before target reached");
    AST_ACC_TEST: assert property (
        cycle_done && st_ff.compute_mode_select == ADCPC_ACCUM && !st_ff.accumulator_clear_request |-> test)
        else $error("accumulate mode skipped threshold test");

    COV_BURST: cover property (st_ff.retrigger ##[1:20] (cycle_done && !nxt_st.retrigger));
    COV_THR: cover property ($rose(st_ff.channel_threshold_flag));
    COV_AOV: cover property ($rose(st_ff.accumulator_overflow_flag));
    COV_LPF: cover property (test && st_ff.compute_mode_select == ADCPC_LPF);
endmodule

// ---- tb/adcpc_conv_model.sv ----
`timescale 1ns/1ps
module adcpc_conv_model
    import adcpc_pkg::*;
#(
    parameter int LAT = 3
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             go,
    input  wire logic             retrigger,
    input  wire logic [RES_W-1:0] sample,
    output logic                  conv_done,
    output logic      [RES_W-1:0] conv_data
);
    typedef struct packed {
        logic [3:0]       wait_cnt;
        logic             done;
        logic [RES_W-1:0] data;
    } adcpc_model_state_type;

    adcpc_model_state_type state_ff;
    adcpc_model_state_type nxt_state;

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.done = 1'b0;
        // idle data toggles so a stale result is never taken as fresh
        nxt_state.data = ~state_ff.data;
        if (go || retrigger) begin
            nxt_state.wait_cnt = 4'(LAT);
        end else if (state_ff.wait_cnt != 4'h0) begin
            nxt_state.wait_cnt = state_ff.wait_cnt - 4'h1;
        end
        if (state_ff.wait_cnt == 4'h1) begin
            nxt_state.done = 1'b1;
            nxt_state.data = sample;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign conv_done = state_ff.done;
    assign conv_data = state_ff.data;
endmodule

// ---- tb/adc_post_conversion_compute_bench.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); end end
module adc_post_conversion_compute_bench;
    import adcpc_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              conv_done;
    logic [RES_W-1:0]  conv_data;
    logic              start_evt = 1'b0;
    logic              retrigger;
    logic              done_flag;
    logic              thr_flag;
    logic              ovf_flag;
    logic [RES_W-1:0]  sample = '0;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                fail_count = 0;
    int                checks_done = 0;
    int                retrig_seen = 0;

    adcpc_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_data(conv_data), .start_evt(start_evt), .retrigger(retrigger),
        .conversion_done_flag(done_flag), .channel_threshold_flag(thr_flag), .accumulator_overflow_flag(ovf_flag));
    adcpc_conv_model #(.LAT(3)) i_conv (.core_clk(core_clk), .rst_n(rst_n), .go(start_evt),
        .retrigger(retrigger), .sample(sample), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (retrigger === 1'b1) retrig_seen++;
    end

    function automatic logic [DATA_W-1:0] ctrl(input logic [2:0] mode, input logic ds, input logic [2:0] shift,
                                                input logic [2:0] tmd, input logic [2:0] esel);
        return DATA_W'(mode) | (DATA_W'(ds) << CTRL_DBL_BIT) | (DATA_W'(shift) << CTRL_SHIFT_LSB) |
               (DATA_W'(tmd) << CTRL_TMD_LSB) | (DATA_W'(esel) << CTRL_ESEL_LSB);
    endfunction

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-raises psel in this time step
        @(posedge core_clk);
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] mask, input logic [DATA_W-1:0] exp);
        apb(1'b0, a, '0);
        `CHK(rd & mask, exp)
    endtask

    task automatic conv(input logic [RES_W-1:0] s);
        int n = 0;
        sample    <= s;
        start_evt <= 1'b1;
        @(posedge core_clk);
        start_evt <= 1'b0;
        while (conv_done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 40) begin
            fail_count++;
            $display("mismatch at %0t: conversion never finished", $time);
        end
        repeat (2) @(posedge core_clk);
    endtask

    // clear is given the five cycles of the clear allowance before the bit is checked
    task automatic clr(input logic [DATA_W-1:0] c);
        apb(1'b1, REG_CTRL, c | (32'h1 << CTRL_CLR_BIT));
        repeat (5) @(posedge core_clk);
        rchk(REG_CTRL, 32'h1 << CTRL_CLR_BIT, 32'h0);
        apb(1'b1, REG_STAT, 32'h00000600);
    endtask

    task automatic summarize;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rchk(REG_STAT, 32'h000007FF, 32'h0);
        apb(1'b0, 8'hFC, '0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, REG_CTRL, ctrl(3'h0, 1'b0, 3'h0, 3'h7, 3'h0));
        conv(10'h155);
        conv(10'h2AA);
        rchk(REG_RES, 32'h03FF03FF, 32'h015502AA);
        rchk(REG_ACC, 32'h0003FFFF, 32'h0);
        `CHK({done_flag, thr_flag, ovf_flag}, 3'b110)
        apb(1'b1, REG_STAT, 32'h00000600);
        apb(1'b1, REG_STPT, 32'h00000200);
        apb(1'b1, REG_LTH, 32'h0);
        apb(1'b1, REG_CTRL, ctrl(3'h0, 1'b0, 3'h0, 3'h1, 3'h2));
        conv(10'h100);
        `CHK(thr_flag, 1'b1)
        rchk(REG_ERR, 32'h000FFFFF, 32'h000FFF00);
        // accumulate, shift right by 2 (divide by 4), flag when filter output exceeds upper limit
        clr(ctrl(3'h1, 1'b0, 3'h2, 3'h6, 3'h5));
        apb(1'b1, REG_STPT, 32'h0);
        apb(1'b1, REG_UTH, 32'h0000013F);
        conv(10'h3FF);
        conv(10'h100);
        `CHK(thr_flag, 1'b0)
        conv(10'h001);
        `CHK(thr_flag, 1'b1)
        rchk(REG_ACC, 32'h0003FFFF, 32'h00000500);
        rchk(REG_FLTR, 32'h0003FFFF, 32'h00000140);
        rchk(REG_STAT, 32'h000001FF, 32'h00000003);
        for (int i = 0; i < 254; i++) conv(10'h3FF);
        rchk(REG_STAT, 32'h000001FF, 32'h000000FF);
        conv(10'h3FF);
        rchk(REG_STAT, 32'h000001FF, 32'h000001FF);
        `CHK(ovf_flag, 1'b1)
        clr(ctrl(3'h2, 1'b0, 3'h1, 3'h7, 3'h0));
        `CHK(ovf_flag, 1'b0)
        rchk(REG_STAT, 32'h000001FF, 32'h0);
        rchk(REG_ACC, 32'h0003FFFF, 32'h0);
        apb(1'b1, REG_REP, 32'h00000002);
        conv(10'd10);
        `CHK(thr_flag, 1'b0)
        conv(10'd20);
        `CHK(thr_flag, 1'b1)
        rchk(REG_ACC, 32'h0003FFFF, 32'd30);
        apb(1'b1, REG_STAT, 32'h00000602);
        conv(10'd40);
        rchk(REG_ACC, 32'h0003FFFF, 32'd40);
        rchk(REG_STAT, 32'h000004FF, 32'h00000001);
        `CHK(retrig_seen, 0)
        apb(1'b1, REG_REP, 32'h00000004);
        apb(1'b1, REG_CTRL, ctrl(3'h3, 1'b0, 3'h2, 3'h7, 3'h5));
        conv(10'd5);
        for (int n = 0; n < 60 && rd[7:0] !== 8'h04; n++) apb(1'b0, REG_STAT, '0);
        repeat (10) @(posedge core_clk);
        rchk(REG_ACC, 32'h0003FFFF, 32'd20);
        rchk(REG_STAT, 32'h000000FF, 32'h00000004);
        rchk(REG_FLTR, 32'h0003FFFF, 32'd5);
        `CHK(retrig_seen, 3)
        clr(ctrl(3'h4, 1'b0, 3'h1, 3'h0, 3'h0));
        conv(10'd100);
        conv(10'd100);
        rchk(REG_ACC, 32'h0003FFFF, 32'd150);
        clr(ctrl(3'h1, 1'b1, 3'h0, 3'h0, 3'h0));
        conv(10'd100);
        conv(10'd300);
        rchk(REG_ACC, 32'h0003FFFF, 32'd200);
        `CHK(retrig_seen, 3)
        summarize();
    end
endmodule
